//--- acspi_consts.svh
// Constants of the accelerometer serial slave port: word layout, field
// positions, reset values and timing counts.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef ACSPI_CONSTS_SVH
`define ACSPI_CONSTS_SVH

// Word and counter sizes
`define ACSPI_WORD_W      16
`define ACSPI_CNT_W       5
`define ACSPI_LAST_CNT    5'h10
`define ACSPI_DATA_W      10
`define ACSPI_CTRL_W      8

// Command word fields
`define ACSPI_SENSOR_BIT  13
`define ACSPI_WRITE_BIT   11
`define ACSPI_REQ_SQ2     12
`define ACSPI_REQ_SQ1     15
`define ACSPI_REQ_SQ0     14
`define ACSPI_CH_HI       1
`define ACSPI_CH_LO       0

// Response word fields
`define ACSPI_PAR_BIT     12
`define ACSPI_PT_HI       11
`define ACSPI_PT_LO       10
`define ACSPI_ERR_PD_BIT  3
`define ACSPI_ERR_HF_BIT  2
`define ACSPI_RESP_RST    16'h1000

// Payload type codes
`define ACSPI_PT_SENSOR   2'h1
`define ACSPI_PT_SELFTEST 2'h2
`define ACSPI_PT_EXCEPT   2'h3

// Control register layout and reset value
`define ACSPI_TCD_BIT     0
`define ACSPI_STE_BIT     1
`define ACSPI_CTRL_RST    8'h00

// Channel select codes
`define ACSPI_CH_XLSB     2'h0
`define ACSPI_CH_YLSB     2'h1
`define ACSPI_CH_XMSB     2'h2
`define ACSPI_CH_YMSB     2'h3

`endif

//--- acspi_pkg.sv
// Types shared by the accelerometer serial slave port.
// Assumes acspi_consts.svh is reachable by bare name.
`include "acspi_consts.svh"
`default_nettype none

package acspi_pkg;
    // Command handling states, one-hot
    typedef enum logic [2:0] {
        ACSPI_IDLE    = 3'h1,
        ACSPI_DECODE  = 3'h2,
        ACSPI_RESPOND = 3'h4
    } acspi_state_t;

    // Payload type tag of a response
    typedef enum logic [1:0] {
        ACSPI_PT_NONE_E  = 2'h0,
        ACSPI_PT_SENS_E  = `ACSPI_PT_SENSOR,
        ACSPI_PT_SELF_E  = `ACSPI_PT_SELFTEST,
        ACSPI_PT_EXC_E   = `ACSPI_PT_EXCEPT
    } acspi_ptype_t;
endpackage

`default_nettype wire

//--- acspi_sync.sv
// Two-flop level synchroniser for signals entering the system clock domain.
// Assumes each bit is a level that stays put for several system clocks.
`include "acspi_consts.svh"
`default_nettype none

module acspi_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    // Levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_o <= '0;
        end else if (clk_en) begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule // acspi_sync

`default_nettype wire

//--- acspi_link.sv
// Serial-clock side of the port: shift register, bit counter, word hand-off
// and serial data output.
// Assumes the master drives sck idle low and keeps select low for a word.
`include "acspi_consts.svh"
`default_nettype none

module acspi_link (
    // Serial pins
    input  wire logic        sck,
    input  wire logic        chip_select_n,
    input  wire logic        mosi,
    output logic             miso_o,
    output logic             miso_oe,
    // System side
    input  wire logic        rst,
    input  wire logic [15:0] resp_i,
    output logic      [15:0] cmd_word_o,
    output logic             cmd_tgl_o
);
    logic [`ACSPI_CNT_W-1:0] cnt_q;
    logic [15:0]             rx_q;
    logic [15:0]             tx_q;
    logic                    done_q;
    logic                    ld_q;
    logic                    first_q;

    // Sample mosi at rising sck; select high holds counter clear
    always_ff @(posedge sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            cnt_q <= '0;
            rx_q  <= 16'h0000;
        end else if (cnt_q != `ACSPI_LAST_CNT) begin
            rx_q  <= {rx_q[14:0], mosi};
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // Output shifting at falling sck, reloaded per selection
    always_ff @(negedge sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            tx_q   <= 16'h0000;
            ld_q   <= 1'b0;
            done_q <= 1'b0;
        end else begin
            if (cnt_q == 5'h01) begin
                tx_q <= {resp_i[14:0], 1'b0};
                ld_q <= 1'b1;
            end else if (cnt_q > 5'h01 && cnt_q < `ACSPI_LAST_CNT) begin
                tx_q <= {tx_q[14:0], 1'b0};
            end
            if (cnt_q == `ACSPI_LAST_CNT) begin
                done_q <= 1'b1;
            end
        end
    end

    // First response bit is set up as the select falls
    always_ff @(negedge chip_select_n or posedge rst) begin
        if (rst) begin
            first_q <= 1'b0;
        end else begin
            first_q <= resp_i[15];
        end
    end

    // Full word latched once, at the falling edge after bit sixteen
    always_ff @(negedge sck or posedge rst) begin
        if (rst) begin
            cmd_word_o <= 16'h0000;
            cmd_tgl_o  <= 1'b0;
        end else if (!chip_select_n && cnt_q == `ACSPI_LAST_CNT
                     && !done_q) begin
            cmd_word_o <= rx_q;
            cmd_tgl_o  <= ~cmd_tgl_o;
        end
    end

    // Data pin driven only while selected
    assign miso_o  = ld_q ? tx_q[15] : first_q;
    assign miso_oe = ~chip_select_n;

    AST_SEL_IDLE: assert property (@(posedge sck) disable iff (rst)
        chip_select_n |-> cnt_q == 5'h00)
        else $error("bit counter not clear while deselected");

    // Checked as select rises, so a reset between frames cannot trip it
    AST_WORD_LATCH: assert property (
        @(posedge chip_select_n) disable iff (rst)
        done_q |-> cmd_word_o == rx_q)
        else $error("latched command differs from shifted word");
endmodule // acspi_link

`default_nettype wire

//--- acspi_core.sv
// Top of the accelerometer serial slave port: command decode, control
// register, response building and the crossing between both clocks.
// Assumes sensor samples arrive in the sys_clk domain with a valid strobe.
//
// How it works
// - Device is slave only; never drives serial clock or select.
// - Mode 0: data changes at falling edge, sampled at rising edge.
// - Sixteen bits, MSB first, both directions at once.
// - Clock edges reach the shift register only while selected.
// - Data output driven only while selected, released otherwise.
// - After sixteenth rising edge the shifted word feeds the internal bus.
// - Next falling edge latches that word as the address.
// - Addressed register updated before the next selection begins.
// - Select rising ends the transfer for both parties.
// - Command bit 13 high requests an acceleration byte.
// - Command bit 13 low reads or writes the control register.
// - One 8-bit control register, readable and writable.
// - Four readable bytes: MSB and LSB of x and y.
// - Bit set disables compensation; other bit set enables self-test.
// - The two control bits drive separate outputs; either one set tags acceleration reads 10.
// - Heater regulation fault raises the hardware error flag.
// - Response bit 12 makes the whole word odd parity.
// - Response bits 11:10 tag the payload type.
// - Acceleration read while powered down reports a conditions error.
// - Self-test active: acceleration reads tagged with code 10.
`include "acspi_consts.svh"
`default_nettype none

module acspi_core #(
    parameter int DATA_W = `ACSPI_DATA_W
) (
    // Clock, reset, enable
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              clk_en,
    // Serial link
    input  wire logic              sck,
    input  wire logic              chip_select_n,
    input  wire logic              mosi,
    output logic                   miso_o,
    output logic                   miso_oe,
    // Sensor samples and status levels
    input  wire logic [DATA_W-1:0] x_data,
    input  wire logic [DATA_W-1:0] y_data,
    input  wire logic              data_valid,
    input  wire logic              powered_down,
    input  wire logic              heater_loop_fail,
    // Control and status outputs
    output logic                   temp_comp_disable,
    output logic                   self_test_enable,
    output logic                   heater_fault_flag,
    output logic                   cmd_done
);
    acspi_pkg::acspi_state_t state_q;
    acspi_pkg::acspi_state_t state_d;
    logic [15:0]             link_word;
    logic                    link_tgl;
    logic [2:0]              sync_lv;
    logic                    tgl_seen_q;
    logic                    cmd_evt;
    logic [15:0]             cmd_q;
    logic [15:0]             resp_q;
    logic [15:0]             resp_d;
    logic [7:0]              ctrl_q;
    logic [7:0]              ctrl_d;
    logic [DATA_W-1:0]       x_q;
    logic [DATA_W-1:0]       y_q;

    // Odd-parity bit for the other fifteen bits of a word
    function automatic logic par_bit(input logic [15:0] w);
        logic [15:0] m;
        m = w;
        m[`ACSPI_PAR_BIT] = 1'b0;
        par_bit = ~(^m);
    endfunction

    // Byte selected by the channel field of a request
    function automatic logic [7:0] pick_byte(input logic [1:0] ch,
                                             input logic [DATA_W-1:0] x,
                                             input logic [DATA_W-1:0] y);
        logic [15:0] xe;
        logic [15:0] ye;
        xe = 16'(x);
        ye = 16'(y);
        unique case (ch)
            `ACSPI_CH_XLSB: pick_byte = xe[7:0];
            `ACSPI_CH_YLSB: pick_byte = ye[7:0];
            `ACSPI_CH_XMSB: pick_byte = xe[15:8];
            `ACSPI_CH_YMSB: pick_byte = ye[15:8];
        endcase
    endfunction

    // Serial-clock side
    acspi_link u_link (
        .sck           (sck),
        .chip_select_n (chip_select_n),
        .mosi          (mosi),
        .miso_o        (miso_o),
        .miso_oe       (miso_oe),
        .rst           (rst),
        .resp_i        (resp_q),
        .cmd_word_o    (link_word),
        .cmd_tgl_o     (link_tgl)
    );

    // Toggle and pin levels brought into sys_clk
    acspi_sync #(.WIDTH(3)) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .async_i ({link_tgl, powered_down, heater_loop_fail}),
        .sync_o  (sync_lv)
    );

    assign cmd_evt = sync_lv[2] ^ tgl_seen_q;

    // Remember the last toggle level seen
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tgl_seen_q <= 1'b0;
        end else if (clk_en) begin
            tgl_seen_q <= sync_lv[2];
        end
    end

    // Command handling sequence
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            acspi_pkg::ACSPI_IDLE: begin
                if (cmd_evt) begin
                    state_d = acspi_pkg::ACSPI_DECODE;
                end
            end
            acspi_pkg::ACSPI_DECODE:  state_d = acspi_pkg::ACSPI_RESPOND;
            acspi_pkg::ACSPI_RESPOND: state_d = acspi_pkg::ACSPI_IDLE;
            default:                  state_d = acspi_pkg::ACSPI_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= acspi_pkg::ACSPI_IDLE;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // Command word taken from the stable link latch
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cmd_q <= 16'h0000;
        end else if (clk_en && state_q == acspi_pkg::ACSPI_IDLE
                     && cmd_evt) begin
            cmd_q <= link_word;
        end
    end

    // Sensor sample snapshot
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            x_q <= '0;
            y_q <= '0;
        end else if (clk_en && data_valid) begin
            x_q <= x_data;
            y_q <= y_data;
        end
    end

    // Next control value: write only for a control command with write bit
    always_comb begin
        ctrl_d = ctrl_q;
        if (state_q == acspi_pkg::ACSPI_DECODE && !cmd_q[`ACSPI_SENSOR_BIT]
            && cmd_q[`ACSPI_WRITE_BIT]) begin
            ctrl_d = cmd_q[7:0];
        end
    end

    // Control register, written before the next selection can begin
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `ACSPI_CTRL_RST;
        end else if (clk_en) begin
            ctrl_q <= ctrl_d;
        end
    end

    // Each control bit drives its own output alone
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            temp_comp_disable <= 1'b0;
            self_test_enable  <= 1'b0;
        end else if (clk_en) begin
            temp_comp_disable <= ctrl_d[`ACSPI_TCD_BIT];
            self_test_enable  <= ctrl_d[`ACSPI_STE_BIT];
        end
    end

    // Response word built from the decoded command
    always_comb begin
        resp_d = 16'h0000;
        resp_d[15:13] = {cmd_q[`ACSPI_REQ_SQ2], cmd_q[`ACSPI_REQ_SQ1],
                         cmd_q[`ACSPI_REQ_SQ0]};
        if (cmd_q[`ACSPI_SENSOR_BIT]) begin
            if (sync_lv[1] || sync_lv[0]) begin
                resp_d[11:10] = acspi_pkg::ACSPI_PT_EXC_E;
                resp_d[`ACSPI_ERR_PD_BIT] = sync_lv[1];
                resp_d[`ACSPI_ERR_HF_BIT] = sync_lv[0];
            end else begin
                resp_d[11:10] = (ctrl_q[`ACSPI_STE_BIT]
                                 || ctrl_q[`ACSPI_TCD_BIT])
                              ? acspi_pkg::ACSPI_PT_SELF_E
                              : acspi_pkg::ACSPI_PT_SENS_E;
                resp_d[7:0] = pick_byte(cmd_q[1:0], x_q, y_q);
            end
        end else begin
            resp_d[11:10] = acspi_pkg::ACSPI_PT_SENS_E;
            resp_d[7:0]   = ctrl_d;
        end
        resp_d[`ACSPI_PAR_BIT] = par_bit(resp_d);
    end

    // Response published for the next selection
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            resp_q <= `ACSPI_RESP_RST;
        end else if (clk_en && state_q == acspi_pkg::ACSPI_DECODE) begin
            resp_q <= resp_d;
        end
    end

    // Status outputs
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            heater_fault_flag <= 1'b0;
            cmd_done          <= 1'b0;
        end else if (clk_en) begin
            heater_fault_flag <= sync_lv[0];
            cmd_done          <= (state_q == acspi_pkg::ACSPI_DECODE);
        end
    end

    AST_PARITY: assert property (
        @(posedge sys_clk) disable iff (rst)
        ^resp_q == 1'b1)
        else $error("response word lacks odd parity");

    AST_PD_ERROR: assert property (
        @(posedge sys_clk) disable iff (rst)
        (clk_en && state_q == acspi_pkg::ACSPI_DECODE
         && cmd_q[`ACSPI_SENSOR_BIT] && sync_lv[1])
        |=> resp_q[11:10] == 2'h3 && resp_q[3])
        else $error("powered-down read not reported");

    AST_HF_ERROR: assert property (
        @(posedge sys_clk) disable iff (rst)
        (clk_en && state_q == acspi_pkg::ACSPI_DECODE
         && cmd_q[`ACSPI_SENSOR_BIT] && sync_lv[0])
        |=> resp_q[11:10] == 2'h3 && resp_q[2])
        else $error("heater fault not reported");

    AST_SELFTEST_TAG: assert property (
        @(posedge sys_clk) disable iff (rst)
        (clk_en && state_q == acspi_pkg::ACSPI_DECODE
         && cmd_q[`ACSPI_SENSOR_BIT] && !sync_lv[1] && !sync_lv[0]
         && self_test_enable)
        |=> resp_q[11:10] == 2'h2)
        else $error("self-test read not tagged 10");

    AST_BYTE_SEL: assert property (
        @(posedge sys_clk) disable iff (rst)
        (clk_en && state_q == acspi_pkg::ACSPI_DECODE
         && cmd_q[`ACSPI_SENSOR_BIT] && !sync_lv[1] && !sync_lv[0]
         && cmd_q[1:0] == 2'h0)
        |=> resp_q[7:0] == $past(x_q[7:0]))
        else $error("x low byte not returned");

    AST_CTRL_WRITE: assert property (
        @(posedge sys_clk) disable iff (rst)
        (clk_en && state_q == acspi_pkg::ACSPI_DECODE
         && !cmd_q[`ACSPI_SENSOR_BIT] && cmd_q[`ACSPI_WRITE_BIT])
        |=> ctrl_q == $past(cmd_q[7:0]) && resp_q[7:0] == ctrl_q)
        else $error("control write lost");

    AST_CTRL_OUTS: assert property (
        @(posedge sys_clk) disable iff (rst)
        temp_comp_disable == ctrl_q[0] && self_test_enable == ctrl_q[1])
        else $error("control outputs disagree with register");

    AST_CMD_FLOW: assert property (
        @(posedge sys_clk) disable iff (rst)
        (clk_en && state_q == acspi_pkg::ACSPI_IDLE && cmd_evt)
        |=> state_q == acspi_pkg::ACSPI_DECODE
        ##1 state_q == acspi_pkg::ACSPI_RESPOND || !clk_en)
        else $error("command not handled in order");

    AST_OE_SEL: assert property (
        @(posedge sys_clk) disable iff (rst)
        miso_oe == !chip_select_n)
        else $error("data output enable wrong");

    COV_SENSOR_READ: cover property (@(posedge sys_clk) disable iff (rst)
        state_q == acspi_pkg::ACSPI_DECODE && cmd_q[`ACSPI_SENSOR_BIT]);
    COV_CTRL_WRITE: cover property (@(posedge sys_clk) disable iff (rst)
        state_q == acspi_pkg::ACSPI_DECODE && cmd_q[`ACSPI_WRITE_BIT]
        && !cmd_q[`ACSPI_SENSOR_BIT]);
    COV_EXCEPTION: cover property (@(posedge sys_clk) disable iff (rst)
        resp_q[11:10] == 2'h3);
endmodule // acspi_core

`default_nettype wire

//--- acspi_master_model.sv
// Serial host model: drives clock, select and data in mode 0 and
// gathers the reply word, one frame per call.
// Assumes the bench resolves the port's data line from its enable.
`default_nettype none

module acspi_master_model (
    // Serial pins towards the port
    output logic      sck,
    output logic      chip_select_n,
    output logic      mosi,
    // Reply line, resolved by the bench
    input  wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;

    // Half period of the 6 ns link clock
    localparam real HALF = 3.0;

    // Clock rests low and select high outside frames
    initial begin
        sck = 1'b0;
        chip_select_n = 1'b1;
        mosi = 1'b0;
    end

    // One frame of nb bits, MSB first; fewer than 16 cuts the word short
    task automatic xfer(input logic [15:0] tx, input int nb,
                        output logic [15:0] rx);
        rx = 16'h0000;
        chip_select_n = 1'b0;
        mosi = tx[15];
        #(2 * HALF);
        for (int i = 0; i < nb; i++) begin
            rx[15 - i] = miso; // Sampled just before rising
            sck = 1'b1;
            #HALF;
            sck = 1'b0; // Last fall latches the command word
            if (i < 15) mosi = tx[14 - i];
            #HALF;
        end
        #HALF;
        chip_select_n = 1'b1;
        mosi = ~mosi; // Released line shows no stale value
    endtask

    // Clock pulses while deselected, which the port must ignore
    task automatic stray(input int n);
        repeat (n) begin
            sck = 1'b1;
            #HALF;
            sck = 1'b0;
            #HALF;
        end
    endtask
endmodule // acspi_master_model

`default_nettype wire

//--- accel_spi_slave_port_tb_top.sv
// Bench of the accelerometer serial port: a table of commands, then stray
// clocks, a cut-off frame and a reset in mid-run.
// Assumes acspi_core as top and acspi_master_model as the serial host.
`default_nettype none

`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    error_cnt++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
    end end

module accel_spi_slave_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // Design inputs and outputs
    logic        sys_clk, rst, clk_en, data_valid;
    logic        powered_down, heater_loop_fail;
    logic [9:0]  x_data, y_data;
    wire         sck, chip_select_n, mosi, miso_w;
    logic        miso_o, miso_oe, cmd_done;
    logic        temp_comp_disable, self_test_enable, heater_fault_flag;
    // Bench state
    int          error_cnt = 0;
    int          n_checks = 0;
    logic [15:0] rx, prev_exp;
    logic [7:0]  ctrl;
    // Rows: {self test, comp off, powered down, heater fail, command}
    // Rows 5 to 11 walk the host's self-test check
    logic [19:0] rows [16] = '{20'h02000, 20'h0D001, 20'h02002, 20'h06003,
        20'h40801, 20'h42000, 20'hC0803, 20'hC2002, 20'h80802, 20'h80000,
        20'h00800, 20'h22000, 20'h1A001, 20'h70855, 20'h42003, 20'h00800};

    // Data line floats when the port lets go of it
    assign miso_w = miso_oe ? miso_o : 1'bz;

    // 10 MHz system clock
    always #50 sys_clk = ~sys_clk;

    acspi_core #(.DATA_W(10)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .sck(sck),
        .chip_select_n(chip_select_n), .mosi(mosi), .miso_o(miso_o),
        .miso_oe(miso_oe), .x_data(x_data), .y_data(y_data),
        .data_valid(data_valid), .powered_down(powered_down),
        .heater_loop_fail(heater_loop_fail),
        .temp_comp_disable(temp_comp_disable),
        .self_test_enable(self_test_enable),
        .heater_fault_flag(heater_fault_flag), .cmd_done(cmd_done));

    acspi_master_model host_u (
        .sck(sck), .chip_select_n(chip_select_n), .mosi(mosi),
        .miso(miso_w));

    // Reply word the port should publish for command c
    function automatic logic [15:0] exp_resp(logic [15:0] c, logic pd,
                                             logic hf);
        logic [15:0] r;
        logic [9:0]  d;
        r = 16'h0000;
        r[15:13] = {c[12], c[15], c[14]};
        d = c[0] ? y_data : x_data;
        if (!c[13]) begin
            r[11:10] = 2'h1;
            r[7:0] = ctrl;
        end else if (pd || hf) begin
            r[11:10] = 2'h3;
            r[3] = pd;
            r[2] = hf;
        end else begin
            r[11:10] = (ctrl[1:0] != 2'h0) ? 2'h2 : 2'h1;
            r[7:0] = c[1] ? {6'h00, d[9:8]} : d[7:0];
        end
        r[12] = ~^r;
        return r;
    endfunction

    // Full frame, then a bounded wait for the command to be answered
    task automatic frame(input logic [15:0] c);
        int k;
        host_u.xfer(c, 16, rx);
        k = 0;
        while (cmd_done !== 1'b1 && k < 40) begin
            @(negedge sys_clk);
            k++;
        end
        `CHK("cmd_done", 1'b1, cmd_done)
        repeat (6) @(negedge sys_clk);
        `CHK("miso_oe", 1'b0, miso_oe)
    endtask

    // Counts, verdict and end of run
    task automatic results();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #2000000;
        error_cnt++;
        results();
    end

    // Main sequence
    initial begin
        int k;
        sys_clk = 1'b0;
        rst = 1'b1;
        clk_en = 1'b1;
        data_valid = 1'b1;
        powered_down = 1'b0;
        heater_loop_fail = 1'b0;
        x_data = 10'h2A5;
        y_data = 10'h15A;
        ctrl = 8'h00;
        prev_exp = 16'h1000;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        foreach (rows[i]) begin
            powered_down <= rows[i][17];
            heater_loop_fail <= rows[i][16];
            repeat (4) @(posedge sys_clk);
            frame(rows[i][15:0]);
            `CHK("response", prev_exp, rx)
            if (!rows[i][13] && rows[i][11]) ctrl = rows[i][7:0];
            prev_exp = exp_resp(rows[i][15:0], rows[i][17], rows[i][16]);
            `CHK("temp_comp_disable", rows[i][18], temp_comp_disable)
            `CHK("self_test_enable", rows[i][19], self_test_enable)
            `CHK("heater_fault_flag", rows[i][16], heater_fault_flag)
        end
        // Stray clocks and a cut-off frame leave no trace
        powered_down <= 1'b0;
        heater_loop_fail <= 1'b0;
        host_u.stray(5);
        host_u.xfer(16'h0803, 7, rx);
        k = 0;
        repeat (12) begin
            @(negedge sys_clk);
            if (cmd_done === 1'b1) k++;
        end
        `CHK("short frame done", 0, k)
        frame(16'h0803);
        `CHK("response", prev_exp, rx)
        ctrl = 8'h03;
        `CHK("temp_comp_disable", 1'b1, temp_comp_disable)
        // Reset in mid-run clears the control bits and the reply
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK("temp_comp_disable", 1'b0, temp_comp_disable)
        `CHK("self_test_enable", 1'b0, self_test_enable)
        @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        frame(16'h2000);
        `CHK("response", 16'h1000, rx)
        results();
    end
endmodule // accel_spi_slave_port_tb_top

`undef CHK
`default_nettype wire
